// ### logic/unlock_gate_params.svh
`ifndef UNLOCK_GATE_PARAMS_SVH
`define UNLOCK_GATE_PARAMS_SVH
// ----------------------------------------
// Register indices (printed offsets)
// ----------------------------------------
`define IDX_KEY_FIRST      12'h150
`define IDX_KEY_SECOND     12'h151
`define IDX_KEY_THIRD      12'h152
`define IDX_KEY_FOURTH     12'h153
`define IDX_PROG_CTRL      12'h154
`define IDX_GATE_STATUS    12'h155
`define IDX_FIRST_STAGE    12'h156
// ----------------------------------------
// Fields and values
// ----------------------------------------
`define KEY_RESET          8'h00
`define TRIGGER_BIT        0
`define STATUS_ARMED_BIT   0
`define STATUS_STEP_LSB    1
`define STATUS_STEP_MSB    3
`define FIRST_STAGE_BIT    0
`define AXI_OKAY           2'h0
`define AXI_SLVERR         2'h2
`define ADDR_LSB           2
`define KEY_COUNT          4
`endif

// ### logic/unlock_gate_pkg.sv
package unlock_gate_pkg;
    typedef enum logic [2:0] {
        seq_idle,
        seq_got_first,
        seq_got_second,
        seq_got_third,
        seq_armed
    } seq_state_t;
    typedef logic [7:0] key_t;
endpackage : unlock_gate_pkg

// ### logic/key_compare.sv
`timescale 1ns/100ps
`include "unlock_gate_params.svh"
module key_compare
    import unlock_gate_pkg::*;
#(
    parameter key_t KEY0 = 8'h11,
    parameter key_t KEY1 = 8'h22,
    parameter key_t KEY2 = 8'h33,
    parameter key_t KEY3 = 8'h44
) (
    input  wire logic [7:0]              data,
    output logic      [`KEY_COUNT-1:0]   match
);
    localparam key_t EXPECTED [`KEY_COUNT] = '{KEY0, KEY1, KEY2, KEY3};
    // ----------------------------------------
    // Per-key comparison
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < `KEY_COUNT; i++) begin : g_cmp
            assign match[i] = (data == EXPECTED[i]);
        end
    endgenerate
endmodule : key_compare

// ### logic/otp_program_unlock_gate.sv
`timescale 1ns/100ps
`include "unlock_gate_params.svh"
module otp_program_unlock_gate
    import unlock_gate_pkg::*;
#(
    parameter key_t KEY0 = 8'h11,
    parameter key_t KEY1 = 8'h22,
    parameter key_t KEY2 = 8'h33,
    parameter key_t KEY3 = 8'h44
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             program_start,
    output logic             program_armed
);
    // ----------------------------------------
    // Write channel capture
    // ----------------------------------------
    logic        aw_held;
    logic [11:0] aw_index;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [7:0]  key_store [`KEY_COUNT];
    logic        first_stage_ok;
    seq_state_t  state;
    seq_state_t  next_state;
    logic [`KEY_COUNT-1:0] match;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    wire aw_take   = s_axi_awvalid && s_axi_awready;
    wire w_take    = s_axi_wvalid && s_axi_wready;
    wire aw_have   = aw_held || aw_take;
    wire w_have    = w_held || w_take;
    wire [11:0] aw_idx_now = aw_held ? aw_index : s_axi_awaddr[13:`ADDR_LSB];
    wire [31:0] wd_now     = w_held ? w_data : s_axi_wdata;
    wire [3:0]  ws_now     = w_held ? w_strb : s_axi_wstrb;
    wire do_write  = aw_have && w_have;
    wire lane0     = ws_now[0];
    wire [7:0] wbyte = wd_now[7:0];

    wire hit_k0   = (aw_idx_now == `IDX_KEY_FIRST);
    wire hit_k1   = (aw_idx_now == `IDX_KEY_SECOND);
    wire hit_k2   = (aw_idx_now == `IDX_KEY_THIRD);
    wire hit_k3   = (aw_idx_now == `IDX_KEY_FOURTH);
    wire hit_ctrl = (aw_idx_now == `IDX_PROG_CTRL);
    wire hit_fst  = (aw_idx_now == `IDX_FIRST_STAGE);
    wire hit_stat = (aw_idx_now == `IDX_GATE_STATUS);
    wire w_mapped = hit_k0 || hit_k1 || hit_k2 || hit_k3 || hit_ctrl || hit_fst || hit_stat;
    wire [`KEY_COUNT-1:0] key_hit = {hit_k3, hit_k2, hit_k1, hit_k0};

    key_compare #(
        .KEY0 (KEY0),
        .KEY1 (KEY1),
        .KEY2 (KEY2),
        .KEY3 (KEY3)
    ) u_cmp (
        .data  (wbyte),
        .match (match)
    );

    wire trigger_write = do_write && hit_ctrl && lane0 && wd_now[`TRIGGER_BIT];
    // Start only when armed and first stage still open
    assign program_start = trigger_write && (state == seq_armed) && first_stage_ok;
    assign program_armed = (state == seq_armed);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_held  <= 1'b0;
            aw_index <= 12'h000;
        end else if (do_write) begin
            aw_held  <= 1'b0;
        end else if (aw_take) begin
            aw_held  <= 1'b1;
            aw_index <= s_axi_awaddr[13:`ADDR_LSB];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (do_write) begin
            w_held <= 1'b0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_mapped ? `AXI_OKAY : `AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Key storage (write-only from the bus)
    // ----------------------------------------
    genvar k;
    generate
        for (k = 0; k < `KEY_COUNT; k++) begin : g_key
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    key_store[k] <= `KEY_RESET;
                end else if (do_write && key_hit[k] && lane0) begin
                    key_store[k] <= wbyte;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            first_stage_ok <= 1'b0;
        end else if (do_write && hit_fst && lane0) begin
            first_stage_ok <= wd_now[`FIRST_STAGE_BIT];
        end
    end

    // ----------------------------------------
    // Unlock sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        if (do_write) begin
            case (state)
                seq_idle:       next_state = (hit_k0 && match[0]) ? seq_got_first : seq_idle;
                seq_got_first:  next_state = (hit_k1 && match[1]) ? seq_got_second
                                            : (hit_k0 && match[0]) ? seq_got_first : seq_idle;
                seq_got_second: next_state = (hit_k2 && match[2]) ? seq_got_third
                                            : (hit_k0 && match[0]) ? seq_got_first : seq_idle;
                seq_got_third:  next_state = (hit_k3 && match[3]) ? seq_armed
                                            : (hit_k0 && match[0]) ? seq_got_first : seq_idle;
                seq_armed:      next_state = seq_idle;
                default:        next_state = seq_idle;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= seq_idle;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    wire [11:0] ar_idx  = s_axi_araddr[13:`ADDR_LSB];
    wire r_key  = (ar_idx >= `IDX_KEY_FIRST) && (ar_idx <= `IDX_KEY_FOURTH);
    wire r_ctrl = (ar_idx == `IDX_PROG_CTRL);
    wire r_stat = (ar_idx == `IDX_GATE_STATUS);
    wire r_fst  = (ar_idx == `IDX_FIRST_STAGE);
    wire [2:0] step = state[2:0];
    wire [31:0] stat_word = {28'h0000000, step, program_armed};
    wire [31:0] fst_word  = {31'h00000000, first_stage_ok};
    // Keys never leave on the read path
    wire [31:0] rd_mux = r_key  ? 32'h0000_0000 :
                         r_stat ? stat_word :
                         r_fst  ? fst_word : 32'h0000_0000;
    wire r_mapped = r_key || r_ctrl || r_stat || r_fst;

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= r_mapped ? `AXI_OKAY : `AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    wire key_read = s_axi_arvalid && s_axi_arready && r_key;

    property p_key_reads_zero;
        @(posedge clock) disable iff (!rst_n)
        key_read |=> (s_axi_rvalid && s_axi_rdata == 32'h0000_0000);
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero)
        else $error("key register read returned nonzero");

    property p_armed_clears;
        @(posedge clock) disable iff (!rst_n)
        (state == seq_armed && do_write) |=> (state == seq_idle);
    endproperty
    a_armed_clears: assert property (p_armed_clears)
        else $error("unlock survived next write");

    // Stored fourth key is checked apart from the compare path
    property p_start_needs_both;
        @(posedge clock) disable iff (!rst_n)
        program_start |-> (first_stage_ok && program_armed && key_store[3] == KEY3);
    endproperty
    a_start_needs_both: assert property (p_start_needs_both)
        else $error("program start without both stages");

    property p_arm_after_fourth;
        @(posedge clock) disable iff (!rst_n)
        $rose(program_armed) |-> $past(state == seq_got_third && hit_k3 && match[3]);
    endproperty
    a_arm_after_fourth: assert property (p_arm_after_fourth)
        else $error("armed without correct fourth key");

    property p_wrong_resets;
        @(posedge clock) disable iff (!rst_n)
        (do_write && state == seq_got_second && !(hit_k2 && match[2]) && !(hit_k0 && match[0]))
            |=> (state == seq_idle);
    endproperty
    a_wrong_resets: assert property (p_wrong_resets)
        else $error("bad write did not restart sequence");

    property p_key_a_store;
        @(posedge clock) disable iff (!rst_n)
        (do_write && hit_k0 && lane0) |=> (key_store[0] == $past(wbyte));
    endproperty
    a_key_a_store: assert property (p_key_a_store)
        else $error("key A not stored");

    property p_key_d_store;
        @(posedge clock) disable iff (!rst_n)
        (do_write && hit_k3 && lane0) |=> (key_store[3] == $past(wbyte));
    endproperty
    a_key_d_store: assert property (p_key_d_store)
        else $error("key D not stored");

    property p_resp_follows;
        @(posedge clock) disable iff (!rst_n)
        do_write |=> s_axi_bvalid;
    endproperty
    a_resp_follows: assert property (p_resp_follows)
        else $error("write response missing");

    property p_start_disarms;
        @(posedge clock) disable iff (!rst_n)
        program_start |=> !program_armed;
    endproperty
    a_start_disarms: assert property (p_start_disarms)
        else $error("unlock survived program start");

    property p_no_start_when_first_closed;
        @(posedge clock) disable iff (!rst_n)
        (do_write && hit_ctrl && !first_stage_ok) |-> !program_start;
    endproperty
    a_no_start_when_first_closed: assert property (p_no_start_when_first_closed)
        else $error("program start with first stage closed");

    property p_key_a_restarts;
        @(posedge clock) disable iff (!rst_n)
        (do_write && hit_k0 && match[0] && state != seq_armed) |=> (state == seq_got_first);
    endproperty
    a_key_a_restarts: assert property (p_key_a_restarts)
        else $error("correct first key did not restart sequence");

    property p_read_keeps_state;
        @(posedge clock) disable iff (!rst_n)
        !do_write |=> $stable(state);
    endproperty
    a_read_keeps_state: assert property (p_read_keeps_state)
        else $error("sequence moved without a write");

    c_armed: cover property (@(posedge clock) disable iff (!rst_n) $rose(program_armed));
    c_start: cover property (@(posedge clock) disable iff (!rst_n) program_start);
    c_forfeit: cover property (@(posedge clock) disable iff (!rst_n)
        state == seq_armed && do_write && !trigger_write);
endmodule : otp_program_unlock_gate

// ### verification/otp_program_unlock_gate_tb.sv
`timescale 1ns/100ps
`include "unlock_gate_params.svh"
module otp_program_unlock_gate_tb;
    import unlock_gate_pkg::*;
    // ----------------------------------------
    // Keys differ from defaults to catch hard-wired values
    // ----------------------------------------
    localparam key_t        K0       = 8'h5a;
    localparam key_t        K1       = 8'hc3;
    localparam key_t        K2       = 8'h96;
    localparam key_t        K3       = 8'h0f;
    localparam logic [11:0] IDX_NONE = 12'h200;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, program_start, program_armed;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [33:0] exp_b[$], exp_r[$];
    int          num_errors = 0, tests_run = 0, starts = 0, i;
    integer      seed = 32'h2cdd;
    always #2.5 clock = ~clock;
    otp_program_unlock_gate #(.KEY0(K0), .KEY1(K1), .KEY2(K2), .KEY3(K3)) uut (
        .clock(clock), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .program_start(program_start), .program_armed(program_armed)
    );
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input logic [33:0] act, input logic [33:0] exp);
        tests_run++;
        if (act !== exp) begin
            num_errors++;
            $display("FAIL t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("errors=%0d comparisons=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic hang;
        num_errors++;
        $display("FAIL t=%0t act=%h exp=%h", $time, 1'b0, 1'b1);
        complete_run();
    endtask : hang
    // ----------------------------------------
    // Monitor: oldest note against each answer
    // ----------------------------------------
    always @(posedge clock) begin
        if (program_start === 1'b1) starts++;
        if (bvalid === 1'b1 && bready) begin
            if (exp_b.size() == 0) hang();
            else chk({32'h0, bresp}, exp_b.pop_front());
        end
        if (rvalid === 1'b1 && rready) begin
            if (exp_r.size() == 0) hang();
            else chk({rresp, rdata}, exp_r.pop_front());
        end
    end
    // ----------------------------------------
    // Bus master tasks
    // ----------------------------------------
    task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
        int n;
        exp_b.push_back({32'h0, er});
        @(posedge clock);
        awaddr  <= {idx, 2'b00};
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clock);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 60) hang();
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] idx, input logic [31:0] ed, input logic [1:0] er);
        int n;
        exp_r.push_back({er, ed});
        @(posedge clock);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clock);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 60) hang();
        rready <= 1'b0;
    endtask : rd
    // Only the third key varies, so one task covers good and bad runs
    task automatic seq4(input key_t third);
        wr(`IDX_KEY_FIRST, {24'h0, K0}, `AXI_OKAY);
        wr(`IDX_KEY_SECOND, {24'h0, K1}, `AXI_OKAY);
        wr(`IDX_KEY_THIRD, {24'h0, third}, `AXI_OKAY);
        wr(`IDX_KEY_FOURTH, {24'h0, K3}, `AXI_OKAY);
    endtask : seq4
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(12'(`IDX_KEY_FIRST + i), $random(seed), `AXI_OKAY);
            rd(12'(`IDX_KEY_FIRST + i), 32'h0, `AXI_OKAY);
        end
        rd(IDX_NONE, 32'h0, `AXI_SLVERR);
        wr(IDX_NONE, $random(seed), `AXI_SLVERR);
        wr(`IDX_FIRST_STAGE, 32'h1, `AXI_OKAY);
        rd(`IDX_FIRST_STAGE, 32'h1, `AXI_OKAY);
        seq4(K2);
        chk(program_armed, 1'b1);
        rd(`IDX_GATE_STATUS, 32'h9, `AXI_OKAY);
        rd(`IDX_GATE_STATUS, 32'h9, `AXI_OKAY);
        wr(`IDX_PROG_CTRL, 32'h1, `AXI_OKAY);
        chk(starts, 1);
        chk(program_armed, 1'b0);
        rd(`IDX_PROG_CTRL, 32'h0, `AXI_OKAY);
        seq4(K2);
        wr(`IDX_KEY_FIRST, {24'h0, K0}, `AXI_OKAY);
        chk(program_armed, 1'b0);
        rd(`IDX_GATE_STATUS, 32'h0, `AXI_OKAY);
        wr(`IDX_KEY_FIRST, {24'h0, K0}, `AXI_OKAY);
        wr(`IDX_KEY_SECOND, {24'h0, K1}, `AXI_OKAY);
        wr(`IDX_KEY_FIRST, {24'h0, K0}, `AXI_OKAY);
        rd(`IDX_GATE_STATUS, 32'h2, `AXI_OKAY);
        seq4(K2);
        wr(IDX_NONE, 32'h1, `AXI_SLVERR);
        chk(program_armed, 1'b0);
        wr(`IDX_PROG_CTRL, 32'h1, `AXI_OKAY);
        chk(starts, 1);
        seq4(K2 ^ 8'(({$random(seed)} % 255) + 1));
        chk(program_armed, 1'b0);
        rd(`IDX_GATE_STATUS, 32'h0, `AXI_OKAY);
        wr(`IDX_KEY_FIRST, {24'h0, K0}, `AXI_OKAY);
        wr(`IDX_KEY_THIRD, {24'h0, K2}, `AXI_OKAY);
        rd(`IDX_GATE_STATUS, 32'h0, `AXI_OKAY);
        // Trigger without lane 0 must not start, yet still disarms
        wr(`IDX_FIRST_STAGE, 32'h1, `AXI_OKAY);
        seq4(K2);
        wstrb <= 4'h0;
        wr(`IDX_PROG_CTRL, 32'h1, `AXI_OKAY);
        wstrb <= 4'hf;
        chk(starts, 1);
        chk(program_armed, 1'b0);
        // Without the first stage the gate arms but must not start
        wr(`IDX_FIRST_STAGE, 32'h0, `AXI_OKAY);
        seq4(K2);
        chk(program_armed, 1'b1);
        wr(`IDX_PROG_CTRL, 32'h1, `AXI_OKAY);
        chk(starts, 1);
        chk(program_armed, 1'b0);
        repeat (3) @(posedge clock);
        chk(exp_b.size() + exp_r.size(), 0);
        complete_run();
    end
endmodule : otp_program_unlock_gate_tb
